// ---- src/byte_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes: Any depth from 2 up; flush empties it in one cycle
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ---- src/crc16_byte.sv ----
// Purpose: Byte-wide CRC-16 over x^16 + x^12 + x^5 + 1
// Assumes: clear is a single-cycle strobe; valid takes one byte each cycle it is high; clear wins
// Notes: Running a block followed by its own check bytes, MSB first, leaves zero
`timescale 1ns/1ps
`include "tape_port_params.svh"
module crc16_byte (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clear,
  input wire logic valid,
  input wire logic [7:0] data,
  output logic [15:0] crc
);

  // One byte through the shift register, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Running remainder
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      crc <= `CRC_INIT;
    end else if (clear) begin
      crc <= `CRC_INIT;
    end else if (valid) begin
      crc <= crc_step(crc, data);
    end
  end

endmodule

// ---- src/tape_host_port.sv ----
// Purpose: Host bus side of a streaming tape controller: decode, data, DMA, interrupt, retries
// Assumes: Bus inputs synchronous to clock; resetn is the host reset line, inverted
`timescale 1ns/1ps
`include "tape_port_params.svh"
module tape_host_port
  import tape_port_pkg::*;
#(
  parameter logic [9:0] BASE_ADDR = `BASE_DEFAULT,
  parameter int IRQ_LEVEL = `IRQ_DEFAULT,
  parameter int DMA_CHAN = `DMA_DEFAULT,
  parameter int BUF_DEPTH = `BUF_DEPTH_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire host_bus_t bus,
  input wire logic [3:1] dack_n,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic chrdy_out,
  output logic chrdy_oe_n,
  output logic [7:2] irq,
  output logic [3:1] drq,
  output logic [7:0] fmt_wr_data,
  output logic fmt_wr_valid,
  input wire logic fmt_wr_ready,
  output logic [15:0] fmt_wr_crc,
  input wire logic [7:0] fmt_rd_data,
  input wire logic fmt_rd_valid,
  output logic fmt_rd_ready,
  input wire logic fmt_blk_start,
  input wire logic fmt_chk_valid,
  input wire logic [7:0] fmt_chk_data,
  input wire logic fmt_blk_end,
  output logic fmt_repos,
  output logic fmt_rewrite,
  input wire logic fmt_repos_done,
  output drive_ctl_t drive,
  input wire logic [7:0] drv_status
);
  localparam logic [3:0] WAIT_LD = 4'(`WAIT_CYC);
  localparam int WAIT_N = `WAIT_CYC;

  logic ior_d_r, iow_d_r;
  logic rd_start, wr_start, wr_end;
  logic io_sel, dma_sel;
  logic [7:0] wr_data_r;
  logic [1:0] wr_port_r;
  logic wr_io_r, wr_dma_r;
  logic dma_en_r, dir_wr_r, irq_en_r, flush_r;
  logic irq_pend_r, hard_err_r;
  logic [3:0] wait_cnt_r;
  logic [7:0] drv_stat_r;
  logic [7:0] hold_r;
  logic hold_v_r, hold_v_nxt, hold_acc;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_in_data, f_out_data;
  logic host_push, host_pop, fmt_take;
  logic drq_nxt, done_evt, crc_ok;
  logic [15:0] chk_crc;
  logic [4:0] attempt_r;
  retry_state_t rs_r;

  // Strobe edges and port selection
  assign rd_start = ior_d_r && !bus.ior_n;
  assign wr_start = iow_d_r && !bus.iow_n;
  assign wr_end = !iow_d_r && bus.iow_n;
  assign io_sel = !bus.aen && (bus.addr[9:2] == BASE_ADDR[9:2]);
  assign dma_sel = !dack_n[DMA_CHAN];

  // Strobe history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ior_d_r <= 1'b1;
      iow_d_r <= 1'b1;
    end else begin
      ior_d_r <= bus.ior_n;
      iow_d_r <= bus.iow_n;
    end
  end

  // Write cycle capture while the strobe is low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_data_r <= 8'h00;
      wr_port_r <= 2'h0;
      wr_io_r <= 1'b0;
      wr_dma_r <= 1'b0;
    end else if (!bus.iow_n) begin
      wr_data_r <= bus.data;
      wr_port_r <= bus.addr[1:0];
      wr_io_r <= io_sel;
      wr_dma_r <= dma_sel;
    end
  end

  // Control port: DMA enable, direction, interrupt enable, flush
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dma_en_r <= 1'b0;
      dir_wr_r <= 1'b0;
      irq_en_r <= 1'b0;
      flush_r <= 1'b0;
    end else if (wr_end && wr_io_r && wr_port_r == `PORT_CTRL) begin
      dma_en_r <= wr_data_r[`CTL_DMA_EN];
      dir_wr_r <= wr_data_r[`CTL_DIR_WR];
      irq_en_r <= wr_data_r[`CTL_IRQ_EN];
      flush_r <= wr_data_r[`CTL_FLUSH] || (wr_data_r[`CTL_DIR_WR] != dir_wr_r);
    end else begin
      flush_r <= 1'b0;
    end
  end

  // Drive control and track, held on the drive lines
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drive <= '0;
    end else if (wr_end && wr_io_r) begin
      if (wr_port_r == `PORT_DRIVE) begin
        drive.go <= wr_data_r[`DRV_GO];
        drive.rev <= wr_data_r[`DRV_REV] && wr_data_r[`DRV_GO];
        drive.rst <= wr_data_r[`DRV_RST];
      end else if (wr_port_r == `PORT_TRACK) begin
        drive.track <= wr_data_r[3:0];
      end
    end
  end

  // Buffered drive status
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drv_stat_r <= 8'h00;
    end else begin
      drv_stat_r <= drv_status;
    end
  end

  // Host side of the data buffer
  assign host_push = wr_end && (wr_dma_r || (wr_io_r && wr_port_r == `PORT_DATA));
  assign host_pop = rd_start && (dma_sel || (io_sel && bus.addr[1:0] == `PORT_DATA))
    && !dir_wr_r;
  assign fmt_take = !fmt_wr_valid || fmt_wr_ready;

  // Buffer steering by direction
  always_comb begin
    f_in_valid = dir_wr_r ? host_push : hold_v_r;
    f_in_data = dir_wr_r ? wr_data_r : hold_r;
    f_out_ready = dir_wr_r ? fmt_take : host_pop;
  end

  // Data buffer between host and formatter
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock(clock),
    .resetn(resetn),
    .flush(flush_r),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // Registered stage toward the formatter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fmt_wr_valid <= 1'b0;
      fmt_wr_data <= 8'h00;
    end else if (flush_r || !dir_wr_r) begin
      fmt_wr_valid <= 1'b0;
    end else if (fmt_take) begin
      fmt_wr_valid <= f_out_valid;
      fmt_wr_data <= f_out_data;
    end
  end

  // Holding stage from the formatter; ready comes from a flop
  assign hold_acc = fmt_rd_ready && fmt_rd_valid;
  assign hold_v_nxt = (hold_v_r && !(f_in_ready && !dir_wr_r)) || hold_acc;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_v_r <= 1'b0;
      hold_r <= 8'h00;
      fmt_rd_ready <= 1'b0;
    end else begin
      hold_v_r <= hold_v_nxt && !flush_r;
      fmt_rd_ready <= !hold_v_nxt && !dir_wr_r && !flush_r;
      if (hold_acc) begin
        hold_r <= fmt_rd_data;
      end
    end
  end

  // Host read data and bus drive
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else if (bus.ior_n) begin
      data_oe_n <= 1'b1;
    end else if (rd_start && (io_sel || dma_sel)) begin
      data_oe_n <= 1'b0;
      if (dma_sel || bus.addr[1:0] == `PORT_DATA) begin
        data_out <= f_out_valid ? f_out_data : 8'h00;
      end else if (bus.addr[1:0] == `PORT_CTRL) begin
        data_out <= {attempt_r, rs_r == RS_REPOS, hard_err_r, irq_pend_r};
      end else if (bus.addr[1:0] == `PORT_DRIVE) begin
        data_out <= drv_stat_r;
      end else begin
        data_out <= {4'h0, drive.track};
      end
    end
  end

  // Wait state on formatter accesses, open drain
  assign chrdy_out = 1'b0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chrdy_oe_n <= 1'b1;
      wait_cnt_r <= 4'h0;
    end else if (chrdy_oe_n && (rd_start || wr_start) &&
                 (dma_sel || (io_sel && bus.addr[1:0] == `PORT_DATA))) begin
      chrdy_oe_n <= 1'b0;
      wait_cnt_r <= WAIT_LD - 4'h1;
    end else if (wait_cnt_r != 4'h0) begin
      wait_cnt_r <= wait_cnt_r - 4'h1;
    end else begin
      chrdy_oe_n <= 1'b1;
    end
  end

  // DMA request whenever a byte can move
  assign drq_nxt = dma_en_r && dack_n[DMA_CHAN] && (dir_wr_r ? f_in_ready : f_out_valid);

  // Per-channel request and per-level interrupt outputs
  for (genvar g = 1; g <= 3; g++) begin : g_drq
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        drq[g] <= 1'b0;
      end else begin
        drq[g] <= (g == DMA_CHAN) && drq_nxt;
      end
    end
  end
  for (genvar g = `IRQ_LO; g <= `IRQ_HI; g++) begin : g_irq
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        irq[g] <= 1'b0;
      end else begin
        irq[g] <= (g == IRQ_LEVEL) && irq_pend_r && irq_en_r;
      end
    end
  end

  // Check words for outgoing and readback streams
  crc16_byte u_wr_crc (
    .clock(clock),
    .resetn(resetn),
    .clear(fmt_blk_start),
    .valid(fmt_wr_valid && fmt_wr_ready),
    .data(fmt_wr_data),
    .crc(fmt_wr_crc)
  );
  crc16_byte u_chk_crc (
    .clock(clock),
    .resetn(resetn),
    .clear(fmt_blk_start),
    .valid(fmt_chk_valid),
    .data(fmt_chk_data),
    .crc(chk_crc)
  );
  assign crc_ok = (chk_crc == 16'h0000);

  // Error recovery: reposition and retry, then give up
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rs_r <= RS_RUN;
      attempt_r <= 5'h00;
      fmt_repos <= 1'b0;
      fmt_rewrite <= 1'b0;
    end else begin
      unique case (rs_r)
        RS_RUN: begin
          if (fmt_blk_end && crc_ok) begin
            attempt_r <= 5'h00;
          end else if (fmt_blk_end && attempt_r < `MAX_TRIES) begin
            attempt_r <= attempt_r + 5'h01;
            fmt_repos <= 1'b1;
            fmt_rewrite <= dir_wr_r;
            rs_r <= RS_REPOS;
          end else if (fmt_blk_end) begin
            attempt_r <= 5'h00;
          end
        end
        RS_REPOS: begin
          if (fmt_repos_done) begin
            fmt_repos <= 1'b0;
            fmt_rewrite <= 1'b0;
            rs_r <= RS_RUN;
          end
        end
      endcase
    end
  end

  // Block finished: good, or retries used up
  assign done_evt = (rs_r == RS_RUN) && fmt_blk_end && (crc_ok || attempt_r >= `MAX_TRIES);

  // Sticky pending and error flags; a new event beats the status read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_pend_r <= 1'b0;
      hard_err_r <= 1'b0;
    end else begin
      if (done_evt) begin
        irq_pend_r <= 1'b1;
      end else if (rd_start && io_sel && bus.addr[1:0] == `PORT_CTRL) begin
        irq_pend_r <= 1'b0;
      end
      if (done_evt && !crc_ok) begin
        hard_err_r <= 1'b1;
      end else if (rd_start && io_sel && bus.addr[1:0] == `PORT_CTRL) begin
        hard_err_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_aen_no_drive: assert property ((bus.aen && dack_n == 3'h7) |=> data_oe_n)
    else $error("data bus driven while address enable held");
  a_idle_bus_hiz: assert property (bus.ior_n |=> data_oe_n)
    else $error("data bus driven outside a read");
  a_wait_one_state: assert property ($fell(chrdy_oe_n) |-> ##WAIT_N $rose(chrdy_oe_n))
    else $error("wait state length wrong");
  a_irq_level_only: assert property ((irq & ~(6'h01 << (IRQ_LEVEL - 2))) == 6'h00)
    else $error("unselected interrupt line raised");
  a_irq_on_done: assert property ((done_evt && irq_en_r) |-> ##2 irq[IRQ_LEVEL])
    else $error("no interrupt after block completion");
  a_drq_chan_only: assert property ((drq & ~(3'h1 << (DMA_CHAN - 1))) == 3'h0)
    else $error("request on unselected channel");
  a_drq_byte_ready: assert property ((dma_en_r && dir_wr_r && f_in_ready && dack_n == 3'h7
    && !flush_r) |=> drq[DMA_CHAN])
    else $error("no request with room in buffer");
  a_retry_cap: assert property (attempt_r <= `MAX_TRIES)
    else $error("retry count above limit");
  a_bad_repos: assert property ((rs_r == RS_RUN && fmt_blk_end && !crc_ok
    && attempt_r < `MAX_TRIES) |=> fmt_repos && fmt_rewrite == $past(dir_wr_r))
    else $error("no reposition after check error");
  a_drive_write: assert property ((wr_end && wr_io_r && wr_port_r == `PORT_DRIVE)
    |=> drive.go == $past(wr_data_r[`DRV_GO]))
    else $error("drive control not loaded");
  a_status_read: assert property ((rd_start && io_sel && bus.addr[1:0] == `PORT_DRIVE)
    |=> !data_oe_n && data_out == $past(drv_stat_r))
    else $error("drive status not returned");

  c_dma_write: cover property (drq[DMA_CHAN] ##[1:20] (host_push && wr_dma_r));
  c_retry: cover property (fmt_repos ##[1:50] fmt_repos_done);
  c_give_up: cover property (done_evt && !crc_ok);
  c_status_read: cover property (rd_start && io_sel && bus.addr[1:0] == `PORT_CTRL);

endmodule

// ---- src/tape_port_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the tape host port
// Assumes: Included by bare name from every design file that needs it
// Notes: Constants only
`ifndef TAPE_PORT_PARAMS_SVH
`define TAPE_PORT_PARAMS_SVH

// Port selection and buffer depth
`define BASE_DEFAULT 10'h330
`define BASE_MIN 10'h300
`define BASE_MAX 10'h3f0
`define IRQ_DEFAULT 3
`define IRQ_LO 2
`define IRQ_HI 7
`define DMA_DEFAULT 1
`define BUF_DEPTH_DEFAULT 2

// Port offsets within the selected window
`define PORT_DATA 2'h0
`define PORT_CTRL 2'h1
`define PORT_DRIVE 2'h2
`define PORT_TRACK 2'h3

// Control port bits (write)
`define CTL_DMA_EN 0
`define CTL_DIR_WR 1
`define CTL_FLUSH 2
`define CTL_IRQ_EN 3

// Status port bits (read)
`define ST_PEND 0
`define ST_ERR 1
`define ST_REPOS 2
`define ST_TRY_LSB 3

// Drive control port bits (write)
`define DRV_GO 0
`define DRV_REV 1
`define DRV_RST 2

// Drive status bit for cartridge present
`define DRV_CART 0

// Timing: one host bus clock of wait, rounded up to our clock
`define CLK_NS 20
`define BUS_CLK_NS 210
`define WAIT_CYC ((`BUS_CLK_NS + `CLK_NS - 1) / `CLK_NS)

// Error recovery and check word
`define MAX_TRIES 5'h10
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff

`endif

// ---- src/tape_port_pkg.sv ----
// Purpose: Types shared by the tape host port modules
// Assumes: Nothing
// Notes: Constants live in tape_port_params.svh
package tape_port_pkg;

  // Host bus inputs sampled together
  typedef struct packed {
    logic [9:0] addr;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [7:0] data;
  } host_bus_t;

  // Drive control lines
  typedef struct packed {
    logic go;
    logic rev;
    logic rst;
    logic [3:0] track;
  } drive_ctl_t;

  // Error recovery states
  typedef enum logic [0:0] {
    RS_RUN,
    RS_REPOS
  } retry_state_t;

endpackage

// ---- testbench/host_bus_model.sv ----
// Purpose: Host CPU and DMA controller driving the tape port bus
// Assumes: Requests change 1 ns after the rising edge and hold until released
// Notes: Undriven data lines show the inverse of the last byte seen
`timescale 1ns/1ps
module host_bus_model
  import tape_port_pkg::*;
#(
  parameter int CHAN = 1
) (
  input wire logic clock,
  output host_bus_t bus,
  output logic [3:1] dack_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic chrdy_oe_n
);
  logic [9:0] a_r = 10'h000;
  logic aen_r = 1'b0;
  logic rd_n_r = 1'b1;
  logic wr_n_r = 1'b1;
  logic [7:0] wd_r = 8'h00;
  logic [7:0] last_r = 8'h00;

  initial dack_n = 3'b111;

  // Remember the last byte that anyone put on the data lines
  always @(posedge clock) begin
    if (!wr_n_r) last_r <= wd_r;
    else if (data_oe_n === 1'b0) last_r <= data_out;
  end

  // Bus lines: writer first, then the device, else a changed value
  always_comb begin
    bus.addr = a_r;
    bus.aen = aen_r;
    bus.ior_n = rd_n_r;
    bus.iow_n = wr_n_r;
    bus.data = !wr_n_r ? wd_r : (data_oe_n === 1'b0 ? data_out : ~last_r);
  end

  // One byte cycle; the strobe stays low while channel ready is pulled
  task automatic cycle(input logic wr, aen, ack, input logic [9:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic hung);
    int n;
    n = 0;
    a_r = a;
    aen_r = aen;  // DMA owns the bus
    wd_r = wd;
    if (ack) dack_n[CHAN] = 1'b0;  // Answer on the matching acknowledge
    if (wr) wr_n_r = 1'b0;
    else rd_n_r = 1'b0;
    repeat (2) @(posedge clock) #1;
    while (chrdy_oe_n === 1'b0 && n < 40) begin
      @(posedge clock) #1;
      n++;
    end
    rd = bus.data;
    hung = (n >= 40);
    wr_n_r = 1'b1;
    rd_n_r = 1'b1;
    dack_n = 3'b111;
    aen_r = 1'b0;
    repeat (2) @(posedge clock) #1;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the tape host port
// Assumes: Default base, interrupt level and DMA channel
// Notes: The bench plays the formatter and drive; the host model plays the bus
`timescale 1ns/1ps
`include "tape_port_params.svh"
module tb;
  import tape_port_pkg::*;
  localparam logic [9:0] BASE = `BASE_DEFAULT;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  host_bus_t bus;
  logic [3:1] dack_n, drq;
  logic [7:2] irq;
  logic [7:0] data_out, fmt_wr_data, rd;
  logic [7:0] fmt_rd_data = 8'h00, fmt_chk_data = 8'h00, drv_status = 8'h00;
  logic data_oe_n, chrdy_out, chrdy_oe_n, fmt_wr_valid, fmt_rd_ready, fmt_repos, fmt_rewrite;
  logic fmt_wr_ready = 1'b0, fmt_rd_valid = 1'b0, fmt_blk_start = 1'b0, fmt_chk_valid = 1'b0;
  logic fmt_blk_end = 1'b0, fmt_repos_done = 1'b0, hung, oe_seen = 1'b0;
  logic [15:0] fmt_wr_crc;
  drive_ctl_t drive;
  int bad_count = 0, check_count = 0, wait_len = 0, run_len = 0;

  tape_host_port uut (.clock(clock), .resetn(resetn), .bus(bus), .dack_n(dack_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .chrdy_out(chrdy_out),
    .chrdy_oe_n(chrdy_oe_n), .irq(irq), .drq(drq), .fmt_wr_data(fmt_wr_data),
    .fmt_wr_valid(fmt_wr_valid), .fmt_wr_ready(fmt_wr_ready), .fmt_wr_crc(fmt_wr_crc),
    .fmt_rd_data(fmt_rd_data), .fmt_rd_valid(fmt_rd_valid), .fmt_rd_ready(fmt_rd_ready),
    .fmt_blk_start(fmt_blk_start), .fmt_chk_valid(fmt_chk_valid),
    .fmt_chk_data(fmt_chk_data), .fmt_blk_end(fmt_blk_end), .fmt_repos(fmt_repos),
    .fmt_rewrite(fmt_rewrite), .fmt_repos_done(fmt_repos_done), .drive(drive),
    .drv_status(drv_status));
  host_bus_model host (.clock(clock), .bus(bus), .dack_n(dack_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .chrdy_oe_n(chrdy_oe_n));

  initial begin
    forever #10 clock = ~clock;
  end

  // Length of the last stretch with channel ready pulled low; data bus use
  always @(posedge clock) begin
    if (data_oe_n === 1'b0) oe_seen <= 1'b1;
    if (chrdy_oe_n === 1'b0) run_len <= run_len + 1;
    else if (run_len != 0) begin
      wait_len <= run_len;
      run_len <= 0;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic io(input logic wr, aen, ack, input logic [9:0] a, input logic [7:0] wd);
    host.cycle(wr, aen, ack, a, wd, rd, hung);
    if (hung) begin
      bad_count++;
      $display("BAD at %0t: bus cycle never ended", $time);
      complete_run();
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return fmt_repos;
      1: return irq[3];
      2: return drq[1];
      default: return fmt_rd_ready;
    endcase
  endfunction

  // Bounded wait for one of the watched outputs to go high
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    while (sig(s) !== 1'b1) begin
      tick();
      n++;
      if (n > 20) begin
        bad_count++;
        $display("BAD at %0t: wait ran out", $time);
        complete_run();
      end
    end
  endtask

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
    return c;
  endfunction

  // Readback of a one-byte block with a good or spoiled check word
  task automatic run_block(input logic good);
    logic [15:0] c;
    c = crc_byte(`CRC_INIT, 8'ha5);
    if (!good) c = ~c;
    fmt_blk_start = 1'b1;
    tick();
    fmt_blk_start = 1'b0;
    fmt_chk_valid = 1'b1;
    fmt_chk_data = 8'ha5;
    tick();
    fmt_chk_data = c[15:8];
    tick();
    fmt_chk_data = c[7:0];
    tick();
    fmt_chk_valid = 1'b0;
    tick();
    fmt_blk_end = 1'b1;
    tick();
    fmt_blk_end = 1'b0;
  endtask

  task automatic t_reset();
    resetn = 1'b0;
    repeat (6) tick();
    chk({data_oe_n, chrdy_oe_n, irq, drq}, {2'b11, 6'h00, 3'h0});
    chk({drive, fmt_wr_valid, fmt_repos}, 16'h0000);
    chk(fmt_wr_crc, `CRC_INIT);
    resetn = 1'b1;
    repeat (2) tick();
    $display("t_reset done");
  endtask

  task automatic t_decode();
    logic [9:0] bad_a [3] = '{10'h342, 10'h132, 10'h302};
    io(1, 0, 0, BASE + 10'h2, 8'h02);
    chk(drive, 16'h0000);
    io(1, 0, 0, BASE + 10'h2, 8'h03);
    io(1, 0, 0, BASE + 10'h3, 8'h5a);
    chk(drive, {9'h0, 3'b110, 4'ha});
    foreach (bad_a[i]) io(1, 0, 0, bad_a[i], 8'h00);
    io(1, 1, 0, BASE + 10'h2, 8'h00);
    chk(drive, {9'h0, 3'b110, 4'ha});
    oe_seen = 1'b0;
    io(0, 1, 0, BASE + 10'h2, 8'h00);
    chk(oe_seen, 1'b0);
    drv_status = 8'h81;
    tick();  // Status lines are buffered for one clock before a read sees them
    io(0, 0, 0, BASE + 10'h2, 8'h00);
    chk(rd, 8'h81);
    chk(data_oe_n, 1'b1);
    $display("t_decode done");
  endtask

  task automatic t_wait();
    wait_len = 0;
    io(0, 0, 0, BASE + 10'h1, 8'h00);
    chk(wait_len, 0);
    io(0, 0, 0, BASE, 8'h00);
    chk(wait_len, `WAIT_CYC);
    chk({chrdy_out, chrdy_oe_n}, 2'b01);
    chk(rd, 8'h00);
    $display("t_wait done");
  endtask

  task automatic t_dma_wr();
    logic [15:0] c;
    int k, n, m;
    c = `CRC_INIT;
    k = 0;
    n = 0;
    m = 0;
    io(1, 0, 0, BASE + 10'h1, 8'h03);
    fmt_blk_start = 1'b1;
    tick();
    fmt_blk_start = 1'b0;
    wait_hi(2);
    chk(drq, 3'b001);
    while (drq[1] === 1'b1 && k < 8) begin
      io(1, 1, 1, BASE, 8'h10 + 8'(k));
      k++;
    end
    // Two buffered bytes plus the one waiting at the formatter
    chk(k, `BUF_DEPTH_DEFAULT + 1);
    fmt_wr_ready = 1'b1;
    // Byte on offer is judged before the edge that takes it
    while (n < k && m < 40) begin
      if (fmt_wr_valid === 1'b1) begin
        chk(fmt_wr_data, 8'h10 + 8'(n));
        c = crc_byte(c, fmt_wr_data);
        n++;
      end
      tick();
      m++;
    end
    chk(n, k);
    fmt_wr_ready = 1'b0;
    tick();
    chk(fmt_wr_crc, c);
    $display("t_dma_wr done");
  endtask

  task automatic t_dma_rd();
    io(1, 0, 0, BASE + 10'h1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      fmt_rd_valid = 1'b1;
      fmt_rd_data = i ? 8'h3c : 8'hc3;
      wait_hi(3);
      tick();
    end
    fmt_rd_valid = 1'b0;
    for (int i = 0; i < 2; i++) begin
      wait_hi(2);
      io(0, 1, 1, BASE, 8'h00);
      chk(rd, i ? 8'h3c : 8'hc3);
    end
    $display("t_dma_rd done");
  endtask

  task automatic t_recover();
    io(1, 0, 0, BASE + 10'h1, 8'h0a);
    run_block(0);
    wait_hi(0);
    chk(fmt_rewrite, 1'b1);
    fmt_repos_done = 1'b1;
    tick();
    fmt_repos_done = 1'b0;
    run_block(1);
    wait_hi(1);
    chk(irq, 6'b000010);
    io(0, 0, 0, BASE + 10'h1, 8'h00);
    chk(rd, 8'h01);
    chk(irq, 6'h00);
    io(1, 0, 0, BASE + 10'h1, 8'h08);
    for (int i = 0; i < 16; i++) begin
      run_block(0);
      wait_hi(0);
      chk(fmt_rewrite, 1'b0);
      fmt_repos_done = 1'b1;
      tick();
      fmt_repos_done = 1'b0;
    end
    io(0, 0, 0, BASE + 10'h1, 8'h00);
    chk(rd, 8'h80);
    run_block(0);
    repeat (4) tick();
    chk(fmt_repos, 1'b0);
    io(0, 0, 0, BASE + 10'h1, 8'h00);
    chk(rd, 8'h03);
    $display("t_recover done");
  endtask

  initial begin
    #(20 * 50000);
    bad_count++;
    $display("BAD at %0t: run took too long", $time);
    complete_run();
  end

  initial begin
    t_reset();
    t_decode();
    t_reset();
    t_wait();
    t_dma_wr();
    t_dma_rd();
    t_recover();
    complete_run();
  end
endmodule
